// [bench/mhpm_host.sv]
`timescale 1ns/10ps
`default_nettype none
module mhpm_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  int n_tmo = 0;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one word transfer; both waits share one bound so a dead slave cannot hang us
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    rd = hrdata;
    // released data lines show the inverse so a stale value cannot pass
    hwdata <= ~wd;
    if (n >= 64) n_tmo++;
  endtask
endmodule // mhpm_host
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  import mhpm_pkg::*;
  logic hclk = 0, hresetn = 0, hard_reset = 0, soft_reset = 0, wake_event = 0;
  logic eeprom_load = 0, eeprom_keep_context = 0, frame_da_valid = 0;
  logic receive_everything_bit = 0, receive_all_group_bit = 0;
  logic [31:0] group_hash_word = 0;
  logic [47:0] frame_da = 0;
  wire logic hsel, hwrite, hreadyout, hresp, frame_result_valid, frame_accept;
  wire logic wake_output_pin, config_reset, irq;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans, power_state;
  wire logic [2:0] hsize;
  int n_fail = 0, total_checks = 0, n_cfg = 0, seed = 50812;
  logic [31:0] rd;
  logic [15:0] h2 = 0, h3 = 0;
  logic en = 0, flag = 0, keep = 0;
  logic [1:0] ps = 0;

  mhpm_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .hard_reset, .soft_reset, .wake_event, .eeprom_load, .eeprom_keep_context,
    .receive_everything_bit, .receive_all_group_bit, .group_hash_word, .frame_da_valid, .frame_da,
    .frame_result_valid, .frame_accept, .wake_output_pin, .power_state, .config_reset, .irq);
  mhpm_host host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

  initial begin
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) if (config_reset === 1'b1) n_cfg++;

  function automatic logic [31:0] pm();
    return {16'h0, flag, 6'h0, en, 4'h0, keep, 1'b0, ps};
  endfunction
  function automatic logic [5:0] ref_hash(input logic [47:0] da);
    logic [31:0] c;
    logic b;
    c = 32'hffffffff;
    for (int i = 0; i < 48; i++) begin
      b = c[31] ^ da[40 - 8 * (i / 8) + i % 8];
      c = {c[30:0], 1'b0} ^ (b ? MHPM_CRC_POLY : 32'h0);
    end
    return c[31:26];
  endfunction
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    host.xfer(1'b1, i, d, rd);
    if (host.n_tmo > 0) end_sim;
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    host.xfer(1'b0, i, 32'h0, rd);
    if (host.n_tmo > 0) end_sim;
    `CHK(rd, e)
  endtask
  task automatic bk;
    wr(MHPM_IDX_BANK_SEL, {24'h0, MHPM_BANK_OWN});
  endtask
  task automatic frm(input logic [47:0] da);
    logic [63:0] t;
    logic e;
    t = {h3, h2, group_hash_word};
    e = !da[40] | receive_everything_bit | receive_all_group_bit | t[ref_hash(da)];
    frame_da_valid <= 1'b1;
    frame_da <= da;
    @(posedge hclk);
    frame_da_valid <= 1'b0;
    @(negedge hclk);
    `CHK({frame_result_valid, frame_accept}, {1'b1, e})
    @(posedge hclk);
  endtask
  task automatic end_sim;
    n_fail += host.n_tmo;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    end_sim;
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bk;
    rc(MHPM_IDX_HASH2, 32'h0);
    rc(MHPM_IDX_HASH3, 32'h0);
    rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'h0);
    for (int b = 20; b < 32; b++) begin
      wr(MHPM_IDX_BANK_SEL, 32'(b));
      rc(MHPM_IDX_BANK_SEL, 32'(b));
      rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'h0);
    end
    bk;
    for (int k = 0; k < 24; k++) begin
      h2 = 16'($random(seed));
      h3 = 16'($random(seed));
      group_hash_word <= $random(seed);
      {receive_everything_bit, receive_all_group_bit} <= (k % 3 == 0) ? 2'($random(seed)) : 2'b00;
      wr(MHPM_IDX_HASH2, {16'($random(seed)), h2});
      wr(MHPM_IDX_HASH3, {16'($random(seed)), h3});
      rc(MHPM_IDX_HASH2, {16'h0, h2});
      rc(MHPM_IDX_HASH3, {16'h0, h3});
      frm({16'($random(seed)), 32'($random(seed))} | 48'h0100_0000_0000);
      frm({16'($random(seed)), 32'($random(seed))});
    end
    // reserved and read-only bits are written as ones on purpose
    for (int p = 0; p < 4; p++) begin
      ps = 2'(p);
      en = 1'b1;
      wr(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'hffff_7ffc | 32'(p));
      rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, pm());
      `CHK(power_state, ps)
    end
    wr(MHPM_IDX_IRQ_MASK, 32'h1);
    wake_event <= 1'b1;
    @(posedge hclk);
    wake_event <= 1'b0;
    flag = 1'b1;
    @(negedge hclk);
    `CHK({wake_output_pin, irq, hresp}, 3'b110)
    @(posedge hclk);
    rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, pm());
    rc(MHPM_IDX_IRQ_STAT, 32'h1);
    rc(MHPM_IDX_IRQ_STAT, 32'h0);
    `CHK(irq, 1'b0)
    wr(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'h8103);
    flag = 1'b0;
    rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, pm());
    `CHK(wake_output_pin, 1'b0)
    wr(MHPM_IDX_IRQ_MASK, 32'h0);
    wr(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'h0003);
    en = 1'b0;
    wake_event <= 1'b1;
    @(posedge hclk);
    wake_event <= 1'b0;
    flag = 1'b1;
    rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, pm());
    `CHK({wake_output_pin, irq}, 2'b00)
    wr(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'h0103);
    en = 1'b1;
    soft_reset <= 1'b1;
    @(posedge hclk);
    soft_reset <= 1'b0;
    h2 = 16'h0;
    h3 = 16'h0;
    bk;
    rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, pm());
    rc(MHPM_IDX_HASH3, 32'h0);
    `CHK(n_cfg, 1)
    hard_reset <= 1'b1;
    @(posedge hclk);
    hard_reset <= 1'b0;
    ps = MHPM_PS_D0;
    bk;
    rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, pm());
    `CHK({wake_output_pin, n_cfg}, {1'b1, 32'd2})
    host.xfer(1'b0, MHPM_IDX_IRQ_STAT, 32'h0, rd);
    for (int s = 0; s < 2; s++) begin
      h2 = 16'($random(seed));
      wr(MHPM_IDX_HASH2, {16'h0, h2});
      wr(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'h0103);
      wr(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'h0100);
      if (!keep) h2 = 16'h0;
      if (!keep) bk;
      rc(MHPM_IDX_HASH2, {16'h0, h2});
      rc(MHPM_IDX_IRQ_STAT, keep ? 32'h0 : 32'h2);
      `CHK(n_cfg, 3)
      eeprom_keep_context <= 1'b1;
      eeprom_load <= 1'b1;
      @(posedge hclk);
      eeprom_load <= 1'b0;
      keep = 1'b1;
      rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, pm());
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    {flag, en, keep} = 3'b000;
    bk;
    rc(MHPM_IDX_POWER_MGMT_CTRL_STATUS, 32'h0);
    `CHK(wake_output_pin, 1'b0)
    end_sim;
  end
endmodule // tb
`default_nettype wire

// [hw/mhpm_pkg.sv]
package mhpm_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [7:0] MHPM_IDX_HASH2    = 8'h04;
  localparam logic [7:0] MHPM_IDX_HASH3    = 8'h06;
  localparam logic [7:0] MHPM_IDX_POWER_MGMT_CTRL_STATUS     = 8'h08;
  localparam logic [7:0] MHPM_IDX_IRQ_STAT = 8'h0a;
  localparam logic [7:0] MHPM_IDX_IRQ_MASK = 8'h0c;
  localparam logic [7:0] MHPM_IDX_BANK_SEL = 8'h0e;
  localparam logic [7:0] MHPM_IDX_NONE     = 8'hff;
  localparam int         MHPM_IDX_LSB      = 2;

  localparam logic [7:0] MHPM_BANK_OWN     = 8'h13;
  localparam logic [7:0] MHPM_BANK_RSV_LO  = 8'h14;
  localparam logic [7:0] MHPM_BANK_RSV_HI  = 8'h1f;
  localparam logic [7:0] MHPM_BANK_RST     = 8'h00;

  // power management register fields
  localparam int MHPM_PM_FLAG   = 15;
  localparam int MHPM_PM_EN     = 8;
  localparam int MHPM_PM_KEEP   = 3;
  localparam int MHPM_PM_PS_HI  = 1;
  localparam int MHPM_PM_PS_LO  = 0;

  // interrupt status bits
  localparam int MHPM_IRQ_WAKE  = 0;
  localparam int MHPM_IRQ_CFGRST = 1;
  localparam int MHPM_IRQ_W     = 2;

  localparam logic [15:0] MHPM_HASH_RST = 16'h0000;
  localparam int          MHPM_DA_GROUP = 40;

  typedef enum logic [1:0] {
    MHPM_PS_D0 = 2'b00,
    MHPM_PS_D1 = 2'b01,
    MHPM_PS_D2 = 2'b10,
    MHPM_PS_D3 = 2'b11
  } mhpm_pstate_type;

  localparam logic [31:0] MHPM_CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] MHPM_CRC_INIT = 32'hffffffff;

  // ethernet crc over the address, first octet in [47:40], each octet lsb first
  function automatic logic [5:0] mhpm_hash(input logic [47:0] da);
    logic [31:0] crc;
    logic        fb;
    crc = MHPM_CRC_INIT;
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 8; j++) begin
        fb  = crc[31] ^ da[47 - 8 * k - 7 + j];
        crc = {crc[30:0], 1'b0} ^ (fb ? MHPM_CRC_POLY : 32'h00000000);
      end
    end
    return crc[31:26];
  endfunction
endpackage

// [hw/mhpm_top.sv]
// Notes on behaviour
// - the hash is the six top bits of the address crc; its top two pick a table word, the low four a bit.
// - a group frame whose selected table bit is one is accepted, and dropped when it is zero; individual frames always pass.
// - with receive-everything or receive-all-group set, every group frame is accepted.
// - a wake event sets the wake flag, and the wake pin rises only if the wake enable is set too.
// - the wake flag clears on power-up reset or a written one, never on hardware or software reset.
// - the wake pin falls whenever the wake flag is clear.
// - the wake enable gates the pin, resets at power-up and survives a software reset.
// - with the keep-context bit set, a written move from D3 to D0 resets nothing.
// - with the keep-context bit clear, a written move from D3 to D0 wipes the configuration.
// - a hardware reset wipes the configuration, sets the configuration-reset interrupt status bit and keeps the wake context and the keep-context bit.
// - the keep-context bit is loaded from the eeprom configuration bit.
// - the two power state bits are written to request a state and read back the current one.
// - banks 20 to 31 hold nothing but the bank select register.
// - the two upper table words are 16-bit read/write registers reset to zero.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module mhpm_top
(
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic [31:0] hrdata,
  output var   logic        hreadyout,
  output var   logic        hresp,
  input  wire  logic        hard_reset,
  input  wire  logic        soft_reset,
  input  wire  logic        wake_event,
  input  wire  logic        eeprom_load,
  input  wire  logic        eeprom_keep_context,
  input  wire  logic        receive_everything_bit,
  input  wire  logic        receive_all_group_bit,
  input  wire  logic [31:0] group_hash_word,
  input  wire  logic        frame_da_valid,
  input  wire  logic [47:0] frame_da,
  output var   logic        frame_result_valid,
  output var   logic        frame_accept,
  output var   logic        wake_output_pin,
  output var   logic [1:0]  power_state,
  output var   logic        config_reset,
  output var   logic        irq
);
  import mhpm_pkg::*;

  typedef struct packed {
    logic [7:0]          bank;
    logic [15:0]         hash2;
    logic [15:0]         hash3;
    logic                wake_flag;
    logic                wake_en;
    logic                keep_ctx;
    mhpm_pstate_type     pstate;
    logic [MHPM_IRQ_W-1:0] irq_stat;
    logic [MHPM_IRQ_W-1:0] irq_mask;
    logic                wr_pend;
    logic [7:0]          wr_idx;
    logic                rd_pend;
    logic [7:0]          rd_idx;
    logic [31:0]         rdata;
    logic                ready;
    logic                irq;
    logic                wake_pin;
    logic                cfg_rst;
    logic                fvalid;
    logic                faccept;
  } mhpm_state_type;

  mhpm_state_type st_ff;
  mhpm_state_type nxt_st;

  logic        addr_phase;
  logic [7:0]  addr_idx;
  logic [7:0]  dec_idx;
  logic        own_bank;
  logic        rsv_bank;
  logic [5:0]  hash;
  logic [15:0] word_sel;
  logic [15:0] power_mgmt_ctrl_status_rd;
  logic [31:0] rd_mux;
  logic        wipe;

  assign addr_phase = hsel & htrans[1] & hready;
  assign addr_idx   = haddr[MHPM_IDX_LSB +: 8];
  assign own_bank   = (st_ff.bank == MHPM_BANK_OWN);
  assign rsv_bank   = (st_ff.bank >= MHPM_BANK_RSV_LO) && (st_ff.bank <= MHPM_BANK_RSV_HI);
  assign hash       = mhpm_hash(frame_da);

  // only the bank select register answers outside the own bank
  always_comb begin
    dec_idx = MHPM_IDX_NONE;
    if (addr_idx == MHPM_IDX_BANK_SEL) begin
      dec_idx = MHPM_IDX_BANK_SEL;
    end else if (own_bank && !rsv_bank && haddr[1:0] == 2'b00) begin
      unique case (addr_idx)
        MHPM_IDX_HASH2, MHPM_IDX_HASH3, MHPM_IDX_POWER_MGMT_CTRL_STATUS,
        MHPM_IDX_IRQ_STAT, MHPM_IDX_IRQ_MASK: dec_idx = addr_idx;
        default: dec_idx = MHPM_IDX_NONE;
      endcase
    end
  end

  always_comb begin
    unique case (hash[5:4])
      2'b00: word_sel = group_hash_word[15:0];
      2'b01: word_sel = group_hash_word[31:16];
      2'b10: word_sel = st_ff.hash2;
      2'b11: word_sel = st_ff.hash3;
    endcase
  end

  always_comb begin
    power_mgmt_ctrl_status_rd = 16'h0000;
    power_mgmt_ctrl_status_rd[MHPM_PM_FLAG] = st_ff.wake_flag;
    power_mgmt_ctrl_status_rd[MHPM_PM_EN]   = st_ff.wake_en;
    power_mgmt_ctrl_status_rd[MHPM_PM_KEEP] = st_ff.keep_ctx;
    power_mgmt_ctrl_status_rd[MHPM_PM_PS_HI:MHPM_PM_PS_LO] = st_ff.pstate;
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (st_ff.rd_idx)
      MHPM_IDX_HASH2:    rd_mux[15:0] = st_ff.hash2;
      MHPM_IDX_HASH3:    rd_mux[15:0] = st_ff.hash3;
      MHPM_IDX_POWER_MGMT_CTRL_STATUS:     rd_mux[15:0] = power_mgmt_ctrl_status_rd;
      MHPM_IDX_IRQ_STAT: rd_mux[MHPM_IRQ_W-1:0] = st_ff.irq_stat;
      MHPM_IDX_IRQ_MASK: rd_mux[MHPM_IRQ_W-1:0] = st_ff.irq_mask;
      MHPM_IDX_BANK_SEL: rd_mux[7:0] = st_ff.bank;
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.cfg_rst = 1'b0;
    wipe           = 1'b0;

    // reads take one wait state so a write in the previous data phase is already visible
    if (st_ff.rd_pend) begin
      nxt_st.rd_pend = 1'b0;
      nxt_st.ready   = 1'b1;
      nxt_st.rdata   = rd_mux;
      if (st_ff.rd_idx == MHPM_IDX_IRQ_STAT) begin
        nxt_st.irq_stat = '0;
      end
    end
    nxt_st.wr_pend = 1'b0;
    if (addr_phase && !st_ff.rd_pend) begin
      nxt_st.wr_pend = hwrite;
      nxt_st.wr_idx  = dec_idx;
      nxt_st.rd_pend = !hwrite;
      nxt_st.rd_idx  = dec_idx;
      nxt_st.ready   = hwrite;
    end

    if (st_ff.wr_pend) begin
      unique case (st_ff.wr_idx)
        MHPM_IDX_HASH2: nxt_st.hash2 = hwdata[15:0];
        MHPM_IDX_HASH3: nxt_st.hash3 = hwdata[15:0];
        MHPM_IDX_POWER_MGMT_CTRL_STATUS: begin
          if (hwdata[MHPM_PM_FLAG]) begin
            nxt_st.wake_flag = 1'b0;
          end
          nxt_st.wake_en = hwdata[MHPM_PM_EN];
          nxt_st.pstate  = mhpm_pstate_type'(hwdata[MHPM_PM_PS_HI:MHPM_PM_PS_LO]);
          if (st_ff.pstate == MHPM_PS_D3 && hwdata[MHPM_PM_PS_HI:MHPM_PM_PS_LO] == MHPM_PS_D0
              && !st_ff.keep_ctx) begin
            wipe = 1'b1;
          end
        end
        MHPM_IDX_IRQ_MASK: nxt_st.irq_mask = hwdata[MHPM_IRQ_W-1:0];
        MHPM_IDX_BANK_SEL: nxt_st.bank = hwdata[7:0];
        default: ;
      endcase
    end

    if (eeprom_load) begin
      nxt_st.keep_ctx = eeprom_keep_context;
    end

    // wake flag and enable are wake context and survive every reset but power-up
    if (hard_reset) begin
      nxt_st.pstate = MHPM_PS_D0;
      wipe          = 1'b1;
    end
    if (wipe || soft_reset) begin
      nxt_st.hash2    = MHPM_HASH_RST;
      nxt_st.hash3    = MHPM_HASH_RST;
      nxt_st.irq_mask = '0;
      nxt_st.bank     = MHPM_BANK_RST;
      nxt_st.cfg_rst  = 1'b1;
    end

    // hardware events win over a same-cycle clear
    if (wake_event) begin
      nxt_st.wake_flag = 1'b1;
      nxt_st.irq_stat[MHPM_IRQ_WAKE] = 1'b1;
    end
    if (wipe) begin
      nxt_st.irq_stat[MHPM_IRQ_CFGRST] = 1'b1;
    end

    nxt_st.wake_pin = nxt_st.wake_flag & nxt_st.wake_en;
    nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_mask);

    nxt_st.fvalid  = frame_da_valid;
    // individual addresses are filtered elsewhere and pass here
    nxt_st.faccept = !frame_da[MHPM_DA_GROUP]
                   | receive_everything_bit | receive_all_group_bit
                   | word_sel[hash[3:0]];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff       <= '0;
      st_ff.bank  <= MHPM_BANK_RST;
      st_ff.hash2 <= MHPM_HASH_RST;
      st_ff.hash3 <= MHPM_HASH_RST;
      st_ff.pstate <= MHPM_PS_D0;
      st_ff.wr_idx <= MHPM_IDX_NONE;
      st_ff.rd_idx <= MHPM_IDX_NONE;
      st_ff.ready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata             = st_ff.rdata;
  assign hreadyout          = st_ff.ready;
  assign hresp              = 1'b0;
  assign frame_result_valid = st_ff.fvalid;
  assign frame_accept       = st_ff.faccept;
  assign wake_output_pin    = st_ff.wake_pin;
  assign power_state        = st_ff.pstate;
  assign config_reset       = st_ff.cfg_rst;
  assign irq                = st_ff.irq;

  a_pin_needs_both: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_output_pin |-> (st_ff.wake_flag && st_ff.wake_en))
    else $error("wake pin high without flag and enable");

  a_event_sets_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    (wake_event && st_ff.wake_en && !(st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS)) |=> wake_output_pin)
    else $error("wake event with enable did not raise pin");

  a_flag_survives_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    ((hard_reset || soft_reset) && st_ff.wake_flag && !(st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS))
    |=> st_ff.wake_flag)
    else $error("wake flag lost on hardware or software reset");

  a_clear_drops_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    !st_ff.wake_flag |-> !wake_output_pin)
    else $error("wake pin high with flag clear");

  a_enable_soft_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (soft_reset && !st_ff.wr_pend) |=> (st_ff.wake_en == $past(st_ff.wake_en)))
    else $error("wake enable changed on software reset");

  a_resume_keeps_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS && st_ff.keep_ctx && !hard_reset && !soft_reset)
    |=> !config_reset)
    else $error("context lost though keep bit set");

  a_resume_wipes_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS && !st_ff.keep_ctx && st_ff.pstate == MHPM_PS_D3
     && hwdata[MHPM_PM_PS_HI:MHPM_PM_PS_LO] == MHPM_PS_D0)
    |=> (config_reset && st_ff.hash2 == MHPM_HASH_RST && st_ff.hash3 == MHPM_HASH_RST))
    else $error("resume from D3 did not wipe configuration");

  a_hard_reset_d0: assert property (@(posedge hclk) disable iff (!hresetn)
    hard_reset |=> (power_state == MHPM_PS_D0 && config_reset && st_ff.hash3 == MHPM_HASH_RST))
    else $error("hardware reset did not return to D0 uninitialized");

  a_keep_loaded: assert property (@(posedge hclk) disable iff (!hresetn)
    eeprom_load |=> (st_ff.keep_ctx == $past(eeprom_keep_context)))
    else $error("keep bit not loaded from eeprom");

  a_group_all_accept: assert property (@(posedge hclk) disable iff (!hresetn)
    (receive_everything_bit || receive_all_group_bit) |=> frame_accept)
    else $error("group frame dropped while receive all set");

  a_table_decides: assert property (@(posedge hclk) disable iff (!hresetn)
    (frame_da[MHPM_DA_GROUP] && !receive_everything_bit && !receive_all_group_bit)
    |=> (frame_accept == $past(word_sel[hash[3:0]])))
    else $error("group frame result does not follow table bit");

  a_read_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_phase && !hwrite && !st_ff.rd_pend) |=> !hreadyout ##1 hreadyout)
    else $error("read did not complete after one wait state");

  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.rd_pend && st_ff.rd_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS) |=> (hrdata[14:9] == 6'h00 && hrdata[7:4] == 4'h0
     && hrdata[2] == 1'b0 && hrdata[31:16] == 16'h0000))
    else $error("reserved power bits read nonzero");

  a_flag_write_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS && hwdata[MHPM_PM_FLAG] && !wake_event)
    |=> !st_ff.wake_flag)
    else $error("written one did not clear wake flag");

  a_enable_written: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS)
    |=> (st_ff.wake_en == $past(hwdata[MHPM_PM_EN])))
    else $error("wake enable does not follow the written bit");

  a_state_written: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS && !hard_reset)
    |=> (power_state == $past(hwdata[MHPM_PM_PS_HI:MHPM_PM_PS_LO])))
    else $error("power state does not follow the written field");

  a_keep_read_only: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_POWER_MGMT_CTRL_STATUS && !eeprom_load)
    |=> (st_ff.keep_ctx == $past(st_ff.keep_ctx)))
    else $error("keep bit changed by a register write");

  a_word_written: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.wr_pend && st_ff.wr_idx == MHPM_IDX_HASH2 && !hard_reset && !soft_reset)
    |=> (st_ff.hash2 == $past(hwdata[15:0])))
    else $error("table word did not take the written value");

  a_rsv_bank_blind: assert property (@(posedge hclk) disable iff (!hresetn)
    (addr_phase && !st_ff.rd_pend && rsv_bank && addr_idx != MHPM_IDX_BANK_SEL)
    |=> (st_ff.wr_idx == MHPM_IDX_NONE && st_ff.rd_idx == MHPM_IDX_NONE))
    else $error("register reachable in a reserved bank");

  a_result_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_da_valid |=> frame_result_valid)
    else $error("frame result did not follow the address");

  a_event_marks_stat: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_event |=> st_ff.irq_stat[MHPM_IRQ_WAKE])
    else $error("wake event not recorded in interrupt status");

  a_stat_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff.rd_pend && st_ff.rd_idx == MHPM_IDX_IRQ_STAT && !wake_event && !hard_reset)
    |=> (st_ff.irq_stat == '0 && !irq))
    else $error("status read did not clear the interrupt");

  a_hard_reset_wipes: assert property (@(posedge hclk) disable iff (!hresetn)
    hard_reset |=> (st_ff.irq_mask == '0 && st_ff.bank == MHPM_BANK_RST
                    && st_ff.irq_stat[MHPM_IRQ_CFGRST]))
    else $error("hardware reset kept the configuration");
endmodule // mhpm_top
`default_nettype wire
